/* File: bwc_io_decode.sv */
// I/O window decoder with ISA alias filtering
`timescale 1ns/10ps
`include "bwc_params.svh"
module bwc_io_decode
(
   input wire logic [31:0] io_addr,
   input wire logic [31:0] io_bottom,
   input wire logic [31:0] io_top,
   input wire logic isa_filter,
   output bwc_pkg::bwc_io_dec_t dec
);
   import bwc_pkg::*;
   // Window hit, ISA range and alias test; the low 256 bytes of each 1KB stay forwardable
   wire in_window = (io_addr >= io_bottom) && (io_addr <= io_top);
   wire in_isa_space = io_addr <= `BWC_ISA_SPACE_TOP;
   wire in_alias = (io_addr[9:0] & `BWC_ISA_ALIAS_MASK) != 10'h000;
   wire blocked = isa_filter && in_window && in_isa_space && in_alias;
   assign dec.in_window = in_window;
   assign dec.forward_down = in_window && !blocked;
   assign dec.forward_up = blocked;
endmodule // bwc_io_decode

/* File: bwc_params.svh */
// Offsets, field positions, reset values and fixed values of the bridge window and control registers
`ifndef BWC_PARAMS_SVH
`define BWC_PARAMS_SVH
`define BWC_OFF_PF_BOT_HI 12'h028
`define BWC_OFF_PF_TOP_HI 12'h02C
`define BWC_OFF_IO_HI 12'h030
`define BWC_OFF_CAP_PTR 12'h034
`define BWC_OFF_INT_CTRL 12'h03C
`define BWC_OFF_IRQ_STAT 12'h040
`define BWC_OFF_IRQ_MASK 12'h044
`define BWC_OFF_WIN_BASE 12'h048
`define BWC_OFF_WIN_LIMIT 12'h04C
`define BWC_CAP_PTR_VAL 8'hDC
`define BWC_INT_PIN_VAL 8'h00
`define BWC_INT_LINE_RST 8'h00
`define BWC_BIT_PAR_RESP 0
`define BWC_BIT_SERR_EN 1
`define BWC_BIT_ISA_EN 2
`define BWC_ISA_SPACE_TOP 32'h0000FFFF
`define BWC_ISA_ALIAS_MASK 10'h300
`endif

/* File: bwc_pkg.sv */
// Types shared by the bridge window and control register block
package bwc_pkg;
   // Bridge control bits held by this block
   typedef struct packed {
      logic isa_filter;
      logic serr_forward;
      logic parity_response;
   } bwc_ctrl_t;
   // Forwarding decision for one I/O address
   typedef struct packed {
      logic in_window;
      logic forward_down;
      logic forward_up;
   } bwc_io_dec_t;
   // Sticky event bits
   typedef struct packed {
      logic serr_seen;
      logic parity_seen;
   } bwc_evt_t;
endpackage

/* File: bwc_regs.sv */
// APB register bank for the prefetchable and I/O window high halves and bridge control
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "bwc_params.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - A 32-bit read/write register at 28h holds bits 63:32 of the prefetchable window bottom and resets to zero.
// - A 32-bit read/write register at 2Ch holds bits 63:32 of the prefetchable window top and resets to zero.
// - The low half of 30h holds I/O window bottom bits 31:16, read/write, reset to zero, used for I/O decode.
// - The high half of 30h holds I/O window top bits 31:16, read/write, reset to zero, used for I/O decode.
// - The read-only capability pointer at 34h always reads DCh.
// - The interrupt line byte is read/write, and startup software is expected to write FFh into it.
// - The interrupt pin byte in bits 15:8 is read-only and reports no pin.
// - Control bit 16 ignores secondary parity errors when clear and detects and reports them when set.
// - Control bit 17 blocks secondary system error forwarding when clear and passes it when set.
// - ISA filtering touches only I/O addresses inside the window and within the first 64KB.
// - With filtering on, window addresses in the last 768 bytes of each 1KB are not sent down but sent up.
module bwc_regs
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic secondary_system_error_n,
   input wire logic secondary_parity_error,
   output logic primary_system_error,
   output logic parity_error_report,
   input wire logic [63:0] mem_addr,
   output logic mem_in_window,
   input wire logic [31:0] io_addr,
   output bwc_pkg::bwc_io_dec_t io_dec,
   output bwc_pkg::bwc_ctrl_t ctrl,
   output logic irq
);
   import bwc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] pf_bot_hi_reg;
   logic [31:0] pf_top_hi_reg;
   logic [15:0] io_bot_hi_reg;
   logic [15:0] io_top_hi_reg;
   logic [7:0] int_line_reg;
   bwc_ctrl_t ctrl_reg;
   bwc_evt_t stat_reg;
   bwc_evt_t stat_next;
   bwc_evt_t mask_reg;
   logic [31:0] win_base_reg;
   logic [31:0] win_limit_reg;
   logic [2:0] serr_sync_reg;
   logic [2:0] perr_sync_reg;
   logic serr_level_reg;
   logic perr_level_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic mem_in_window_reg;
   bwc_io_dec_t io_dec_reg;
   bwc_io_dec_t io_dec_comb;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode: every access finishes in its first access cycle
   wire wr_en = psel && penable && pwrite;
   wire sel_pf_bot = paddr == `BWC_OFF_PF_BOT_HI;
   wire sel_pf_top = paddr == `BWC_OFF_PF_TOP_HI;
   wire sel_io = paddr == `BWC_OFF_IO_HI;
   wire sel_cap = paddr == `BWC_OFF_CAP_PTR;
   wire sel_int = paddr == `BWC_OFF_INT_CTRL;
   wire sel_stat = paddr == `BWC_OFF_IRQ_STAT;
   wire sel_mask = paddr == `BWC_OFF_IRQ_MASK;
   wire sel_base = paddr == `BWC_OFF_WIN_BASE;
   wire sel_limit = paddr == `BWC_OFF_WIN_LIMIT;
   wire mapped = sel_pf_bot | sel_pf_top | sel_io | sel_cap | sel_int | sel_stat | sel_mask | sel_base | sel_limit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Byte-lane merge so a partial write keeps the other lanes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      end
      return r;
   endfunction

   wire [31:0] pf_bot_wr = merge(pf_bot_hi_reg, pwdata, pstrb);
   wire [31:0] pf_top_wr = merge(pf_top_hi_reg, pwdata, pstrb);
   wire [31:0] io_wr = merge({io_top_hi_reg, io_bot_hi_reg}, pwdata, pstrb);
   wire [31:0] base_wr = merge(win_base_reg, pwdata, pstrb);
   wire [31:0] limit_wr = merge(win_limit_reg, pwdata, pstrb);

   ////////////////////////////////////////////////////////////////////////////////
   // Window high halves
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pf_bot_hi_reg <= 32'h00000000;
         pf_top_hi_reg <= 32'h00000000;
         io_bot_hi_reg <= 16'h0000;
         io_top_hi_reg <= 16'h0000;
      end
      else
      begin
         if (wr_en && sel_pf_bot)
            pf_bot_hi_reg <= pf_bot_wr;
         if (wr_en && sel_pf_top)
            pf_top_hi_reg <= pf_top_wr;
         if (wr_en && sel_io)
         begin
            io_bot_hi_reg <= io_wr[15:0];
            io_top_hi_reg <= io_wr[31:16];
         end
      end
   end

   // Low-half window bounds: stand-ins for the neighbouring base/limit registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         win_base_reg <= 32'h00000000;
         win_limit_reg <= 32'h00000000;
      end
      else
      begin
         if (wr_en && sel_base)
            win_base_reg <= base_wr;
         if (wr_en && sel_limit)
            win_limit_reg <= limit_wr;
      end
   end

   // Interrupt line byte and bridge control bits; pin and pointer bytes have no storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_line_reg <= `BWC_INT_LINE_RST;
         ctrl_reg <= '0;
      end
      else if (wr_en && sel_int)
      begin
         if (pstrb[0])
            int_line_reg <= pwdata[7:0];
         if (pstrb[2])
            ctrl_reg <= pwdata[18:16];
      end
   end
   assign ctrl = ctrl_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serr_sync_reg <= 3'h7;
         perr_sync_reg <= 3'h0;
         serr_level_reg <= 1'b0;
         perr_level_reg <= 1'b0;
      end
      else
      begin
         serr_sync_reg <= {serr_sync_reg[1:0], secondary_system_error_n};
         perr_sync_reg <= {perr_sync_reg[1:0], secondary_parity_error};
         if (serr_sync_reg[1] == serr_sync_reg[2])
            serr_level_reg <= !serr_sync_reg[2];
         if (perr_sync_reg[1] == perr_sync_reg[2])
            perr_level_reg <= perr_sync_reg[2];
      end
   end

   // Error gating: forwarding and reporting follow the control bits
   assign primary_system_error = serr_level_reg && ctrl_reg.serr_forward;
   assign parity_error_report = perr_level_reg && ctrl_reg.parity_response;

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event wins over a clear in the same cycle
   wire clr_stat = wr_en && sel_stat && pstrb[0];
   always_comb
   begin
      stat_next = stat_reg;
      if (clr_stat)
         stat_next = stat_reg & ~bwc_evt_t'(pwdata[1:0]);
      if (parity_error_report)
         stat_next.parity_seen = 1'b1;
      if (primary_system_error)
         stat_next.serr_seen = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_reg <= '0;
         mask_reg <= '0;
      end
      else
      begin
         stat_reg <= stat_next;
         if (wr_en && sel_mask && pstrb[0])
            mask_reg <= pwdata[1:0];
      end
   end
   assign irq = |(stat_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // Decoders: 64-bit prefetchable compare and the I/O window
   wire [63:0] pf_bottom = {pf_bot_hi_reg, win_base_reg};
   wire [63:0] pf_top = {pf_top_hi_reg, win_limit_reg};
   wire mem_hit = (mem_addr >= pf_bottom) && (mem_addr <= pf_top);
   wire [31:0] io_bottom = {io_bot_hi_reg, win_base_reg[15:0]};
   wire [31:0] io_top = {io_top_hi_reg, win_limit_reg[15:0]};

   bwc_io_decode u_io_decode
   (
      .io_addr(io_addr),
      .io_bottom(io_bottom),
      .io_top(io_top),
      .isa_filter(ctrl_reg.isa_filter),
      .dec(io_dec_comb)
   );

   // Decisions leave through flip-flops so the forwarding logic sees clean levels, at one cycle of latency
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_in_window_reg <= 1'b0;
         io_dec_reg <= '0;
      end
      else
      begin
         mem_in_window_reg <= mem_hit;
         io_dec_reg <= io_dec_comb;
      end
   end
   assign mem_in_window = mem_in_window_reg;
   assign io_dec = io_dec_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; read-only bytes come from constants
   wire [31:0] int_word = {13'h0000, ctrl_reg, `BWC_INT_PIN_VAL, int_line_reg};
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (sel_pf_bot)
         rd_mux = pf_bot_hi_reg;
      else if (sel_pf_top)
         rd_mux = pf_top_hi_reg;
      else if (sel_io)
         rd_mux = {io_top_hi_reg, io_bot_hi_reg};
      else if (sel_cap)
         rd_mux = {24'h000000, `BWC_CAP_PTR_VAL};
      else if (sel_int)
         rd_mux = int_word;
      else if (sel_stat)
         rd_mux = {30'h00000000, stat_reg};
      else if (sel_mask)
         rd_mux = {30'h00000000, mask_reg};
      else if (sel_base)
         rd_mux = win_base_reg;
      else if (sel_limit)
         rd_mux = win_limit_reg;
   end

   // Read data is captured in the setup cycle and stands through the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h00000000;
      else if (psel && !penable)
         prdata_reg <= rd_mux;
   end
   assign prdata = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_pf_bot_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_pf_bot && pstrb == 4'hF) |=> pf_bot_hi_reg == $past(pwdata))
      else $error("prefetch bottom high not written");
   a_pf_top_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_pf_top && pstrb == 4'hF) |=> pf_top_hi_reg == $past(pwdata))
      else $error("prefetch top high not written");
   a_io_low_half: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_io && pstrb == 4'h3) |=> io_bot_hi_reg == $past(pwdata[15:0]) && $stable(io_top_hi_reg))
      else $error("io bottom lane write wrong");
   a_io_high_half: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_io && pstrb == 4'hC) |=> io_top_hi_reg == $past(pwdata[31:16]) && $stable(io_bot_hi_reg))
      else $error("io top lane write wrong");
   a_cap_fixed: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && sel_cap) |-> prdata == 32'h000000DC)
      else $error("capability pointer not DC");
   a_int_line: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_int && pstrb[0]) |=> int_line_reg == $past(pwdata[7:0]))
      else $error("interrupt line not written");
   a_pin_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && sel_int) |-> prdata[15:8] == 8'h00)
      else $error("interrupt pin not zero");
   a_parity_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_reg.parity_response |-> !parity_error_report)
      else $error("parity reported while ignored");
   a_serr_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (!secondary_system_error_n [*4]) ##1 ctrl_reg.serr_forward
      |-> primary_system_error)
      else $error("system error not forwarded");
   a_isa_scope: assert property (@(posedge pclk) disable iff (!presetn)
      (io_addr > 32'h0000FFFF || !io_dec_comb.in_window) |-> !io_dec_comb.forward_up)
      else $error("isa filter outside its scope");
   a_isa_block: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_reg.isa_filter && io_dec_comb.in_window && io_addr < 32'h00010000 && io_addr[9:8] != 2'b00)
      |-> io_dec_comb.forward_up && !io_dec_comb.forward_down)
      else $error("isa alias not redirected");
   a_mem_window: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_addr == pf_bottom || mem_addr == pf_top) && pf_bottom <= pf_top |-> mem_hit)
      else $error("window bound not inclusive");
   a_ro_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel_int && pstrb == 4'h2) |=> $stable(int_line_reg) && $stable(ctrl_reg))
      else $error("read-only byte write had effect");
   a_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
      primary_system_error |=> stat_reg.serr_seen)
      else $error("status not set");

   c_isa_redirect: cover property (@(posedge pclk) disable iff (!presetn) io_dec.forward_up);
   c_mem_hit: cover property (@(posedge pclk) disable iff (!presetn) mem_in_window && pf_top_hi_reg != 32'h0);
   c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_serr_forward: cover property (@(posedge pclk) disable iff (!presetn) primary_system_error);
endmodule // bwc_regs

/* File: bwc_sec_model.sv */
// Model of the secondary bus side that drives the error pins of the bridge
`timescale 1ns/10ps
module bwc_sec_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic serr_cmd,
   input wire logic perr_cmd,
   output logic secondary_system_error_n,
   output logic secondary_parity_error
);
   // Error pin drive, registered so both pins change just after an edge like a real agent
   // The system error line is pulled up on the bus, so it idles high outside a request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         secondary_system_error_n <= 1'b1;
         secondary_parity_error <= 1'b0;
      end
      else
      begin
         secondary_system_error_n <= ~serr_cmd;
         secondary_parity_error <= perr_cmd;
      end
   end
endmodule // bwc_sec_model

/* File: tb_top.sv */
// Self-checking testbench for the bridge window and control register bank
`timescale 1ns/10ps
module tb_top;
   import bwc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr_cmd = 1'b0, perr_cmd = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, io_addr = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic [63:0] mem_addr = 64'h0;
   logic pready, pslverr, pse, per, mw, irq, e, serr_n, perr_pin;
   bwc_io_dec_t io_dec;
   bwc_ctrl_t ctrl;
   int failures = 0, num_checks = 0;

   // Clock at 20 MHz
   always #25 pclk = ~pclk;

   bwc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .secondary_system_error_n(serr_n), .secondary_parity_error(perr_pin), .primary_system_error(pse),
      .parity_error_report(per), .mem_addr(mem_addr), .mem_in_window(mw), .io_addr(io_addr),
      .io_dec(io_dec), .ctrl(ctrl), .irq(irq));
   bwc_sec_model i_sec (.pclk(pclk), .presetn(presetn), .serr_cmd(serr_cmd), .perr_cmd(perr_cmd),
      .secondary_system_error_n(serr_n), .secondary_parity_error(perr_pin));

   ////////////////////////////////////////////////////////////
   // One APB transfer; only the watchdog ends a wait on pready
   task xfer(input [11:0] a, input w, input [31:0] d, input [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task chk(input string nm, input [63:0] seen, input [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input [11:0] a, input [31:0] d, input [3:0] s);
      xfer(a, 1'b1, d, s);
   endtask

   task rchk(input [11:0] a, input [31:0] exp, input string nm);
      xfer(a, 1'b0, 32'h0, 4'h0);
      chk(nm, rd, exp);
   endtask

   // Decisions are registered, so look half a cycle after the edge that takes the new address
   task ichk(input [31:0] a, input [2:0] exp);
      @(posedge pclk);
      io_addr <= a;
      @(posedge pclk);
      @(negedge pclk);
      chk("io_dec", io_dec, exp);
   endtask

   task mchk(input [63:0] a, input exp);
      @(posedge pclk);
      mem_addr <= a;
      @(posedge pclk);
      @(negedge pclk);
      chk("mem_in_window", mw, exp);
   endtask

   // Pin events cross a synchroniser, so allow a fixed settle time before looking
   task settle;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h028, 32'h0, "pf_bot_hi");
      rchk(12'h02C, 32'h0, "pf_top_hi");
      rchk(12'h030, 32'h0, "io_hi");
      rchk(12'h034, 32'h0000_00DC, "cap_ptr");
      rchk(12'h03C, 32'h0, "int_ctrl");
      rchk(12'h040, 32'h0, "irq_stat");
      chk("ctrl", ctrl, 3'b000);
      $display("test reset values done");
      wr(12'h028, 32'hA5A5_5A5A, 4'hF);
      chk("wr_ok", e, 1'b0);
      rchk(12'h028, 32'hA5A5_5A5A, "pf_bot_hi");
      wr(12'h02C, 32'h1234_5678, 4'hF);
      rchk(12'h02C, 32'h1234_5678, "pf_top_hi");
      wr(12'h030, 32'h1111_2222, 4'h3);
      rchk(12'h030, 32'h0000_2222, "io_hi");
      wr(12'h030, 32'h3333_4444, 4'hC);
      rchk(12'h030, 32'h3333_2222, "io_hi");
      wr(12'h034, 32'hFFFF_FFFF, 4'hF);
      rchk(12'h034, 32'h0000_00DC, "cap_ptr");
      wr(12'h03C, 32'hFFFF_FFFF, 4'hF);
      rchk(12'h03C, 32'h0007_00FF, "int_ctrl");
      chk("ctrl", ctrl, 3'b111);
      wr(12'h03C, 32'h0, 4'h4);
      rchk(12'h03C, 32'h0000_00FF, "int_ctrl");
      wr(12'h03C, 32'h0000_FF00, 4'h2);
      rchk(12'h03C, 32'h0000_00FF, "int_pin_ro");
      wr(12'h050, 32'hFFFF_FFFF, 4'hF);
      chk("wr_err", e, 1'b1);
      rchk(12'h050, 32'h0, "unmapped");
      $display("test access kinds done");
      wr(12'h048, 32'h0000_1000, 4'hF);
      wr(12'h04C, 32'h0000_2FFF, 4'hF);
      wr(12'h028, 32'h0000_0001, 4'hF);
      wr(12'h02C, 32'h0000_0002, 4'hF);
      mchk(64'h0000_0001_0000_0FFF, 1'b0);
      mchk(64'h0000_0001_0000_1000, 1'b1);
      mchk(64'h0000_0002_0000_2FFF, 1'b1);
      mchk(64'h0000_0002_0000_3000, 1'b0);
      $display("test prefetch window done");
      wr(12'h030, 32'h0, 4'hF);
      ichk(32'h0000_1100, 3'b110);
      wr(12'h03C, 32'h0004_0000, 4'h4);
      ichk(32'h0000_1100, 3'b101);
      ichk(32'h0000_2C00, 3'b110);
      ichk(32'h0000_3100, 3'b000);
      wr(12'h030, 32'h0001_0001, 4'hF);
      ichk(32'h0001_1100, 3'b110);
      $display("test io window done");
      wr(12'h03C, 32'h0, 4'h4);
      wr(12'h044, 32'h0, 4'hF);
      serr_cmd <= 1'b1;
      perr_cmd <= 1'b1;
      settle();
      chk("pri_serr", pse, 1'b0);
      chk("par_report", per, 1'b0);
      rchk(12'h040, 32'h0, "irq_stat");
      wr(12'h03C, 32'h0003_0000, 4'h4);
      settle();
      chk("pri_serr", pse, 1'b1);
      chk("par_report", per, 1'b1);
      chk("irq", irq, 1'b0);
      rchk(12'h040, 32'h0000_0003, "irq_stat");
      wr(12'h044, 32'h0000_0002, 4'hF);
      @(negedge pclk);
      chk("irq", irq, 1'b1);
      // Events still present, so the set wins over the clear
      wr(12'h040, 32'h0000_0003, 4'h1);
      rchk(12'h040, 32'h0000_0003, "irq_stat_held");
      serr_cmd <= 1'b0;
      perr_cmd <= 1'b0;
      settle();
      chk("pri_serr", pse, 1'b0);
      wr(12'h040, 32'h0000_0003, 4'h1);
      rchk(12'h040, 32'h0, "irq_stat");
      @(negedge pclk);
      chk("irq", irq, 1'b0);
      $display("test error events done");
      final_report();
   end

   // Watchdog well beyond the fewer than two hundred cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      final_report();
   end
endmodule // tb_top
